// >>> rtl/parallel_port_function_mux.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_port_function_mux
  import port_mux_pkg::*;
#(
  parameter int DIV = SYNC_DIV
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] function_select,
  input wire logic [31:0] port_data,
  input wire logic io_update,
  input wire logic [2:0] profile_select,
  input wire logic streaming_enable,
  input wire logic output_shift_keying,
  output logic [7:0] prog_data_hi,
  output logic [7:0] prog_data_lo,
  output logic [7:0] prog_address,
  output logic prog_write,
  output logic prog_read,
  output logic prog_wide,
  output logic serial_active,
  output logic serial_clock,
  output logic serial_select_n,
  output logic serial_data_in,
  output logic serial_data_out,
  output logic serial_port_resync,
  output logic [31:0] frequency_tuning_word,
  output logic [15:0] phase_offset_word,
  output logic [15:0] amplitude_scale_word,
  output logic [31:0] core_frequency,
  output logic [15:0] core_phase,
  output logic [11:0] core_amplitude,
  output logic core_amplitude_enable,
  output logic core_load
);
  // Pins from the host pass three flops; a change is taken when stages two and three agree.
  logic [3:0] fn_s1, fn_s2, fn_s3, fn_q;
  logic [31:0] pd_s1, pd_s2, pd_s3, pd_q;
  logic [2:0] ps_s1, ps_s2, ps_s3, ps_q, ps_prev;
  logic [2:0] ctl_s1, ctl_s2, ctl_s3, ctl_q;
  logic [3:0] next_fn_q;
  logic [31:0] next_pd_q;
  logic [2:0] next_ps_q, next_ctl_q;
  logic tick;
  logic upd_pend, next_upd_pend, upd_seen;
  logic [31:0] next_ftw;
  logic [15:0] next_pow, next_amp;
  logic next_prog_write, next_prog_read, next_prog_wide, next_serial_active;
  logic [31:0] next_core_frequency;
  logic [15:0] next_core_phase;
  logic [11:0] next_core_amplitude;
  logic next_core_load, direct, profile_changed;

  function automatic logic is_direct(input logic [3:0] f);
    return (f >= FN_FREQ_FULL) && (f <= FN_LO_LAST);
  endfunction

  sync_clk_divider #(.DIV(DIV)) u_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  always_comb begin
    next_fn_q = (fn_s2 == fn_s3) ? fn_s3 : fn_q;
    next_pd_q = (pd_s2 == pd_s3) ? pd_s3 : pd_q;
    next_ps_q = (ps_s2 == ps_s3) ? ps_s3 : ps_q;
    next_ctl_q = (ctl_s2 == ctl_s3) ? ctl_s3 : ctl_q;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      {fn_s1, fn_s2, fn_s3, fn_q} <= '0;
      {pd_s1, pd_s2, pd_s3, pd_q} <= '0;
      {ps_s1, ps_s2, ps_s3, ps_q} <= '0;
      {ctl_s1, ctl_s2, ctl_s3, ctl_q} <= '0;
    end else begin
      fn_s1 <= function_select;
      fn_s2 <= fn_s1;
      fn_s3 <= fn_s2;
      fn_q <= next_fn_q;
      pd_s1 <= port_data;
      pd_s2 <= pd_s1;
      pd_s3 <= pd_s2;
      pd_q <= next_pd_q;
      ps_s1 <= profile_select;
      ps_s2 <= ps_s1;
      ps_s3 <= ps_s2;
      ps_q <= next_ps_q;
      ctl_s1 <= {io_update, streaming_enable, output_shift_keying};
      ctl_s2 <= ctl_s1;
      ctl_s3 <= ctl_s2;
      ctl_q <= next_ctl_q;
    end
  end

  // Direct lanes and program strobes are sampled only on the sync tick, so the code must be steady across it; program and serial pins follow each cycle.
  always_comb begin
    direct = is_direct(fn_q);
    next_ftw = frequency_tuning_word;
    next_pow = phase_offset_word;
    next_amp = amplitude_scale_word;
    next_prog_write = 1'b0;
    next_prog_read = 1'b0;
    next_prog_wide = prog_wide;
    next_serial_active = (fn_q == FN_SERIAL);
    if (tick) begin
      case (fn_q)
        FN_PARALLEL: begin
          next_prog_write = pd_q[CTL_WRITE_BIT];
          next_prog_read = pd_q[CTL_READ_BIT] & ~pd_q[CTL_WRITE_BIT];
          next_prog_wide = pd_q[CTL_WIDE_BIT];
        end
        FN_FREQ_FULL: next_ftw = pd_q;
        FN_FREQ_SWAP: next_ftw = {pd_q[15:0], pd_q[31:16]};
        FN_PHASE_AMP: begin
          next_pow = pd_q[31:16];
          next_amp[11:0] = {pd_q[11:8], pd_q[7:0]};
        end
        FN_AMP_PHASE: begin
          next_amp[11:0] = {pd_q[27:24], pd_q[23:16]};
          next_pow = pd_q[15:0];
        end
        4'h6, 4'h7, 4'h8, 4'h9: begin
          next_ftw[31:8] = pd_q[31:8];
          case (2'(fn_q - FN_HI_FIRST))
            2'h0: next_amp[15:8] = pd_q[7:0];
            2'h1: next_pow[15:8] = pd_q[7:0];
            2'h2: next_amp[7:0] = pd_q[7:0];
            default: next_pow[7:0] = pd_q[7:0];
          endcase
        end
        4'hA, 4'hB, 4'hC, 4'hD: begin
          next_ftw[23:0] = pd_q[31:8];
          case (2'(fn_q - FN_LO_FIRST))
            2'h0: next_amp[15:8] = pd_q[7:0];
            2'h1: next_pow[15:8] = pd_q[7:0];
            2'h2: next_amp[7:0] = pd_q[7:0];
            default: next_pow[7:0] = pd_q[7:0];
          endcase
        end
        default: begin
          // Serial and the unused codes leave every holding register alone.
        end
      endcase
    end
  end

  // An update or profile change between ticks is remembered and applied on the next tick.
  always_comb begin
    profile_changed = (ps_q != ps_prev);
    upd_seen = upd_pend | ctl_q[2] | profile_changed;
    next_upd_pend = upd_seen;
    next_core_load = 1'b0;
    next_core_frequency = core_frequency;
    next_core_phase = core_phase;
    next_core_amplitude = core_amplitude;
    if (tick) begin
      next_upd_pend = 1'b0;
      if ((ctl_q[1] && direct) || upd_seen) begin
        next_core_load = 1'b1;
        next_core_frequency = (ctl_q[1] && direct) ? next_ftw : frequency_tuning_word;
        next_core_phase = (ctl_q[1] && direct) ? next_pow : phase_offset_word;
        next_core_amplitude = ((ctl_q[1] && direct) ? next_amp[11:0] :
          amplitude_scale_word[11:0]) & AMP_USED_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      frequency_tuning_word <= FREQ_RESET;
      phase_offset_word <= PHASE_RESET;
      amplitude_scale_word <= AMP_RESET;
      prog_write <= 1'b0;
      prog_read <= 1'b0;
      prog_wide <= 1'b0;
      serial_active <= 1'b0;
      {serial_clock, serial_select_n, serial_data_in, serial_data_out} <= 4'h1 << 2;
      serial_port_resync <= 1'b0;
      {prog_data_hi, prog_data_lo, prog_address} <= '0;
      core_frequency <= FREQ_RESET;
      core_phase <= PHASE_RESET;
      core_amplitude <= 12'h000;
      core_amplitude_enable <= 1'b0;
      core_load <= 1'b0;
      upd_pend <= 1'b0;
      ps_prev <= 3'h0;
    end else begin
      frequency_tuning_word <= next_ftw;
      phase_offset_word <= next_pow;
      amplitude_scale_word <= next_amp;
      prog_write <= next_prog_write;
      prog_read <= next_prog_read;
      prog_wide <= next_prog_wide;
      serial_active <= next_serial_active;
      if (fn_q == FN_PARALLEL) begin
        prog_data_hi <= pd_q[31:24];
        prog_data_lo <= pd_q[23:16];
        prog_address <= pd_q[15:8];
      end
      if (fn_q == FN_SERIAL) begin
        serial_clock <= pd_q[SER_SCLK_BIT];
        serial_select_n <= pd_q[SER_CS_BIT];
        serial_data_in <= pd_q[SER_SDIO_BIT];
        serial_data_out <= pd_q[SER_SDO_BIT];
        serial_port_resync <= pd_q[SER_RESYNC_BIT];
      end
      core_frequency <= next_core_frequency;
      core_phase <= next_core_phase;
      core_amplitude <= next_core_amplitude;
      core_amplitude_enable <= ctl_q[0];
      core_load <= next_core_load;
      upd_pend <= next_upd_pend;
      ps_prev <= ps_q;
    end
  end

  property p_unused_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      (fn_q[3:1] == 3'h7) |=> $stable(frequency_tuning_word) && $stable(phase_offset_word)
        && $stable(amplitude_scale_word);
  endproperty
  a_unused_hold: assert property (p_unused_hold) else $error("unused code changed a register");

  property p_full_freq;
    @(posedge ref_clk) disable iff (sys_rst)
      (tick && fn_q == FN_FREQ_FULL) |=> (frequency_tuning_word == $past(pd_q));
  endproperty
  a_full_freq: assert property (p_full_freq) else $error("full frequency load wrong");

  property p_swap_freq;
    @(posedge ref_clk) disable iff (sys_rst)
      (tick && fn_q == FN_FREQ_SWAP) |=>
        (frequency_tuning_word == {$past(pd_q[15:0]), $past(pd_q[31:16])});
  endproperty
  a_swap_freq: assert property (p_swap_freq) else $error("swapped frequency load wrong");

  property p_phase_amp;
    @(posedge ref_clk) disable iff (sys_rst)
      (tick && fn_q == FN_PHASE_AMP) |=> (phase_offset_word == $past(pd_q[31:16]))
        && (amplitude_scale_word[11:0] == $past(pd_q[11:0]));
  endproperty
  a_phase_amp: assert property (p_phase_amp) else $error("phase and amplitude load wrong");

  property p_amp_phase;
    @(posedge ref_clk) disable iff (sys_rst)
      (tick && fn_q == FN_AMP_PHASE) |=> (phase_offset_word == $past(pd_q[15:0]))
        && (amplitude_scale_word[11:0] == $past(pd_q[27:16]));
  endproperty
  a_amp_phase: assert property (p_amp_phase) else $error("amplitude and phase load wrong");

  property p_serial_ignore;
    @(posedge ref_clk) disable iff (sys_rst)
      (fn_q == FN_SERIAL) |=> $stable(frequency_tuning_word) && !prog_write;
  endproperty
  a_serial_ignore: assert property (p_serial_ignore) else $error("serial code touched data");

  property p_no_stream_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      (!tick) |=> $stable(core_frequency) && !core_load;
  endproperty
  a_no_stream_hold: assert property (p_no_stream_hold) else $error("core moved off tick");

  property p_stream;
    @(posedge ref_clk) disable iff (sys_rst)
      (tick && ctl_q[1] && fn_q == FN_FREQ_FULL) |=> core_load && (core_frequency == $past(pd_q));
  endproperty
  a_stream: assert property (p_stream) else $error("streaming did not reach core");

  property p_osk;
    @(posedge ref_clk) disable iff (sys_rst)
      1'b1 |=> (core_amplitude_enable == $past(ctl_q[0]));
  endproperty
  a_osk: assert property (p_osk) else $error("amplitude enable does not follow keying bit");
endmodule
`default_nettype wire

// >>> shared/port_mux_pkg.sv
package port_mux_pkg;
  localparam int PORT_W = 32;
  localparam int FREQ_W = 32;
  localparam int PHASE_W = 16;
  localparam int AMP_W = 16;
  localparam int AMP_USED_W = 12;
  localparam int ADDR_W = 8;
  localparam int SYNC_DIV = 4;
  localparam logic [3:0] FN_PARALLEL = 4'h0;
  localparam logic [3:0] FN_SERIAL = 4'h1;
  localparam logic [3:0] FN_FREQ_FULL = 4'h2;
  localparam logic [3:0] FN_FREQ_SWAP = 4'h3;
  localparam logic [3:0] FN_PHASE_AMP = 4'h4;
  localparam logic [3:0] FN_AMP_PHASE = 4'h5;
  localparam logic [3:0] FN_HI_FIRST = 4'h6;
  localparam logic [3:0] FN_HI_LAST = 4'h9;
  localparam logic [3:0] FN_LO_FIRST = 4'hA;
  localparam logic [3:0] FN_LO_LAST = 4'hD;
  localparam int CTL_WRITE_BIT = 0;
  localparam int CTL_READ_BIT = 1;
  localparam int CTL_WIDE_BIT = 2;
  localparam int SER_SCLK_BIT = 0;
  localparam int SER_CS_BIT = 1;
  localparam int SER_SDIO_BIT = 2;
  localparam int SER_SDO_BIT = 3;
  localparam int SER_RESYNC_BIT = 4;
  localparam logic [31:0] FREQ_RESET = 32'h0000_0000;
  localparam logic [15:0] PHASE_RESET = 16'h0000;
  localparam logic [15:0] AMP_RESET = 16'h0000;
  localparam logic [11:0] AMP_USED_MASK = 12'hFFF;
endpackage

// >>> rtl/sync_clk_divider.sv
`timescale 1ns/1ps
`default_nettype none
module sync_clk_divider
  import port_mux_pkg::*;
#(
  parameter int DIV = SYNC_DIV
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  output logic tick
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_count = count + 8'h01;
    if (count == 8'(DIV - 1)) begin
      next_count = 8'h00;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic ref_clk,
  output logic [3:0] function_select,
  output logic [31:0] port_data,
  output logic io_update,
  output logic [2:0] profile_select
);
  initial begin
    function_select = 4'hE;
    port_data = 32'h0000_0000;
    io_update = 1'b0;
    profile_select = 3'h0;
  end
  // Code and data change together and then stand for four sync periods.
  // Holding that long keeps any word from being split across lanes.
  task automatic put(input logic [3:0] code, input logic [31:0] data);
    @(negedge ref_clk);
    function_select = code;
    port_data = data;
    repeat (16) @(negedge ref_clk);
  endtask
  // The strobe is held over two sync periods so the device cannot miss it.
  task automatic strobe(input logic use_profile);
    @(negedge ref_clk);
    if (use_profile) begin
      profile_select = profile_select + 3'h1;
    end else begin
      io_update = 1'b1;
    end
    repeat (8) @(negedge ref_clk);
    io_update = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import port_mux_pkg::*;
  logic ref_clk, sys_rst, streaming_enable, output_shift_keying, io_update;
  logic [3:0] function_select;
  logic [31:0] port_data, frequency_tuning_word, core_frequency, ef;
  logic [2:0] profile_select;
  logic [7:0] prog_data_hi, prog_data_lo, prog_address;
  logic prog_write, prog_read, prog_wide, serial_active, serial_clock, serial_select_n;
  logic serial_data_in, serial_data_out, serial_port_resync, core_amplitude_enable, core_load;
  logic [15:0] phase_offset_word, amplitude_scale_word, core_phase, ep, ea;
  logic [11:0] core_amplitude;
  int mismatches, compares, wr_cnt, rd_cnt, ld_cnt;
  host_model u_host_model (.ref_clk(ref_clk), .function_select(function_select),
    .port_data(port_data), .io_update(io_update), .profile_select(profile_select));
  parallel_port_function_mux #(.DIV(4)) u_parallel_port_function_mux (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .function_select(function_select), .port_data(port_data),
    .io_update(io_update), .profile_select(profile_select),
    .streaming_enable(streaming_enable), .output_shift_keying(output_shift_keying),
    .prog_data_hi(prog_data_hi), .prog_data_lo(prog_data_lo), .prog_address(prog_address),
    .prog_write(prog_write), .prog_read(prog_read), .prog_wide(prog_wide),
    .serial_active(serial_active), .serial_clock(serial_clock),
    .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_port_resync(serial_port_resync),
    .frequency_tuning_word(frequency_tuning_word), .phase_offset_word(phase_offset_word),
    .amplitude_scale_word(amplitude_scale_word), .core_frequency(core_frequency),
    .core_phase(core_phase), .core_amplitude(core_amplitude),
    .core_amplitude_enable(core_amplitude_enable), .core_load(core_load));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Pulses last one cycle, so they are counted rather than sampled later.
  always @(posedge ref_clk) begin
    if (prog_write === 1'b1) wr_cnt++;
    if (prog_read === 1'b1) rd_cnt++;
    if (core_load === 1'b1) ld_cnt++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_hold(input logic [15:0] am);
    chk(frequency_tuning_word, ef);
    chk({16'h0000, phase_offset_word}, {16'h0000, ep});
    chk({16'h0000, amplitude_scale_word & am}, {16'h0000, ea & am});
  endtask
  task automatic exp_upd(input logic [3:0] c, input logic [31:0] d);
    case (c)
      4'h2: ef = d;
      4'h3: ef = {d[15:0], d[31:16]};
      4'h4: {ep, ea[11:0]} = {d[31:16], d[11:8], d[7:0]};
      4'h5: {ea[11:0], ep} = {d[27:24], d[23:16], d[15:0]};
      default: ;
    endcase
    if (c >= 4'h6 && c <= 4'hD) begin
      if (c <= 4'h9) ef[31:8] = d[31:8];
      else ef[23:0] = d[31:8];
      case ((c - 4'h2) & 4'h3)
        4'h0: ea[15:8] = d[7:0];
        4'h1: ep[15:8] = d[7:0];
        4'h2: ea[7:0] = d[7:0];
        default: ep[7:0] = d[7:0];
      endcase
    end
  endtask
  task automatic t_prog;
    int w0, r0;
    w0 = wr_cnt;
    u_host_model.put(FN_PARALLEL, 32'h5AC3_4207);
    chk({prog_data_hi, prog_data_lo, prog_address, 8'h00}, 32'h5AC3_4200);
    chk({31'h0, prog_wide}, 32'h1);
    chk({31'h0, wr_cnt > w0}, 32'h1);
    r0 = rd_cnt;
    u_host_model.put(FN_PARALLEL, 32'h0000_0002);
    chk({30'h0, rd_cnt > r0, prog_wide}, 32'h2);
    u_host_model.put(FN_SERIAL, 32'hFFFF_FF15);
    chk({26'h0, serial_active, serial_port_resync, serial_data_out, serial_data_in,
      serial_select_n, serial_clock}, 32'h35);
    chk_hold(16'hFFFF);
    $display("t_prog done");
  endtask
  task automatic t_direct;
    logic [31:0] d;
    for (int c = 2; c < 16; c++) begin
      d = 32'h9E37_79B9 * (c + 1);
      exp_upd(4'(c), d);
      u_host_model.put(4'(c), d);
      chk_hold((c >= 6) ? 16'hFFFF : 16'h0FFF);
    end
    chk(core_frequency, 32'h0000_0000);
    $display("t_direct done");
  endtask
  task automatic t_update;
    int l0;
    l0 = ld_cnt;
    u_host_model.strobe(1'b0);
    repeat (8) @(negedge ref_clk);
    chk({31'h0, ld_cnt > l0}, 32'h1);
    chk(core_frequency, ef);
    chk({16'h0000, core_phase}, {16'h0000, ep});
    chk({20'h0, core_amplitude}, {20'h0, ea[11:0]});
    u_host_model.put(FN_FREQ_FULL, 32'h0F1E_2D3C);
    chk(core_frequency, ef);
    ef = 32'h0F1E_2D3C;
    u_host_model.strobe(1'b1);
    repeat (8) @(negedge ref_clk);
    chk(core_frequency, ef);
    $display("t_update done");
  endtask
  task automatic t_stream;
    streaming_enable = 1'b1;
    u_host_model.put(FN_FREQ_FULL, 32'hC001_D00D);
    chk(core_frequency, 32'hC001_D00D);
    u_host_model.put(FN_PHASE_AMP, 32'h1234_0ABC);
    chk({core_phase, 4'h0, core_amplitude}, 32'h1234_0ABC);
    streaming_enable = 1'b0;
    output_shift_keying = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk({31'h0, core_amplitude_enable}, 32'h1);
    output_shift_keying = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk({31'h0, core_amplitude_enable}, 32'h0);
    $display("t_stream done");
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    end_of_test;
  end
  initial begin
    {mismatches, compares, wr_cnt, rd_cnt, ld_cnt} = '0;
    {ef, ep, ea} = '0;
    sys_rst = 1'b1;
    streaming_enable = 1'b0;
    output_shift_keying = 1'b0;
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_prog;
    t_direct;
    t_update;
    t_stream;
    end_of_test;
  end
endmodule
`default_nettype wire
